//--- lcc_capture.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_capture #(
    parameter int PRE_W = lcc_pkg::LCC_CNT_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Configuration
    input wire logic [1:0] width_sel_i,
    input wire logic [1:0] trig_mode_i,
    input wire logic [31:0] line_mask_i,
    input wire logic [PRE_W-1:0] pretrig_cnt_i,
    input wire logic [PRE_W-1:0] posttrig_cnt_i,
    input wire logic config_load_i,
    input wire logic soft_start_i,
    // Pins from the peripheral
    input wire logic [7:0] port_zero_lines_i,
    input wire logic [7:0] port_one_lines_i,
    input wire logic [7:0] port_two_lines_i,
    input wire logic [7:0] port_three_lines_i,
    input wire logic start_trigger_in_i,
    input wire logic stop_trigger_in_i,
    // Group 1 capture
    output logic [31:0] grp1_data_o,
    output logic grp1_valid_o,
    output logic grp1_strobe_o,
    // Group 2 capture
    output logic [15:0] grp2_data_o,
    output logic grp2_valid_o,
    output logic grp2_strobe_o,
    // Status
    output logic running_o,
    output logic error_o,
    output logic done_o
);
    if (PRE_W < 1 || PRE_W > 32) begin : g_bad_pre_w
        $error("lcc_capture: PRE_W out of range");
    end

    typedef enum logic [1:0] {LCC_IDLE, LCC_ARMED, LCC_RUN, LCC_POST} lcc_state_t;

    localparam int DLY = lcc_pkg::LCC_CAPT_MIN_CYC;
    localparam int DLY_W = 4;
    // Delay counter is only DLY_W bits, so the delay must fit it
    if (lcc_pkg::LCC_CAPT_MIN_CYC + 2 > lcc_pkg::LCC_CAPT_MAX_CYC || DLY < 2 ||
        DLY - 2 >= (1 << DLY_W)) begin : g_bad_window
        $error("lcc_capture: capture window cannot be met");
    end
    localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(DLY - 2);
    localparam logic [1:0] STB_LAST = 2'(lcc_pkg::LCC_STROBE_CYC - 1);

    logic [31:0] lines;
    logic [1:0] trig_sync;

    lcc_sync #(.WIDTH(34)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i({stop_trigger_in_i, start_trigger_in_i, port_three_lines_i,
                  port_two_lines_i, port_one_lines_i, port_zero_lines_i}),
        .sync_o({trig_sync, lines})
    );

    // State
    lcc_state_t state, next_state;
    logic [31:0] ref_lines, next_ref_lines;
    logic trig_start_d, next_trig_start_d;
    logic trig_stop_d, next_trig_stop_d;
    logic [PRE_W-1:0] samp_cnt, next_samp_cnt;
    logic [PRE_W-1:0] post_cnt, next_post_cnt;
    logic error_q, next_error_q;
    logic done_q, next_done_q;
    // Capture pipeline per group
    logic [1:0] pend, next_pend;
    logic [DLY_W-1:0] dly1, next_dly1, dly2, next_dly2;
    logic [31:0] grp1_data, next_grp1_data;
    logic [15:0] grp2_data, next_grp2_data;
    logic grp1_valid, next_grp1_valid, grp2_valid, next_grp2_valid;
    logic [1:0] stb1, next_stb1, stb2, next_stb2;

    logic [31:0] changed;
    logic chg1, chg2, start_edge, stop_edge, capturing, cap1, cap2;

    always_comb begin
        changed = (lines ^ ref_lines) & line_mask_i;
        start_edge = trig_sync[0] & ~trig_start_d;
        stop_edge = trig_sync[1] & ~trig_stop_d;
        chg1 = 1'b0;
        chg2 = 1'b0;
        case (width_sel_i)
            lcc_pkg::LCC_WIDTH_8: begin
                chg1 = |changed[7:0];
                chg2 = |changed[23:16];
            end
            lcc_pkg::LCC_WIDTH_16: begin
                chg1 = |changed[15:0];
                chg2 = |changed[31:16];
            end
            lcc_pkg::LCC_WIDTH_32: begin
                chg1 = |changed;
                chg2 = 1'b0;
            end
            default: begin
                chg1 = 1'b0;
                chg2 = 1'b0;
            end
        endcase
        capturing = (state == LCC_RUN) || (state == LCC_POST);
        cap1 = pend[0] && (dly1 == DLY_LAST);
        cap2 = pend[1] && (dly2 == DLY_LAST);
    end

    // Control sequence
    always_comb begin
        next_state = state;
        next_ref_lines = lines;
        next_trig_start_d = trig_sync[0];
        next_trig_stop_d = trig_sync[1];
        next_samp_cnt = samp_cnt;
        next_post_cnt = post_cnt;
        next_error_q = error_q;
        next_done_q = done_q;
        if (capturing && cap1 && samp_cnt != {PRE_W{1'b1}}) begin
            next_samp_cnt = samp_cnt + 1'b1;
        end
        case (state)
            LCC_IDLE: begin
                if (soft_start_i) begin
                    next_error_q = 1'b0;
                    next_done_q = 1'b0;
                    next_samp_cnt = PRE_W'(lcc_pkg::LCC_CNT_RST);
                    if (trig_mode_i == lcc_pkg::LCC_TRIG_START ||
                        trig_mode_i == lcc_pkg::LCC_TRIG_BOTH) begin
                        next_state = LCC_ARMED;
                    end else begin
                        next_state = LCC_RUN;
                    end
                end
            end
            LCC_ARMED: begin
                // Stop edges here are dropped on purpose
                if (start_edge) begin
                    next_state = LCC_RUN;
                end
            end
            LCC_RUN: begin
                if (stop_edge && (trig_mode_i == lcc_pkg::LCC_TRIG_STOP ||
                                  trig_mode_i == lcc_pkg::LCC_TRIG_BOTH)) begin
                    if (samp_cnt < pretrig_cnt_i) begin
                        next_error_q = 1'b1;
                        next_state = LCC_IDLE;
                    end else if (posttrig_cnt_i == PRE_W'(lcc_pkg::LCC_CNT_RST)) begin
                        next_done_q = 1'b1;
                        next_state = LCC_IDLE;
                    end else begin
                        next_post_cnt = posttrig_cnt_i;
                        next_state = LCC_POST;
                    end
                end
            end
            LCC_POST: begin
                if (cap1) begin
                    next_post_cnt = post_cnt - 1'b1;
                    if (post_cnt == PRE_W'(1)) begin
                        next_done_q = 1'b1;
                        next_state = LCC_IDLE;
                    end
                end
            end
            default: next_state = LCC_IDLE;
        endcase
        if (config_load_i) begin
            next_state = LCC_IDLE;
            next_error_q = 1'b0;
            next_done_q = 1'b0;
        end else if (soft_start_i && state != LCC_IDLE) begin
            next_state = LCC_IDLE;
            next_error_q = 1'b0;
        end
    end

    // Capture pipeline
    always_comb begin
        next_pend = pend;
        next_dly1 = dly1;
        next_dly2 = dly2;
        next_grp1_data = grp1_data;
        next_grp2_data = grp2_data;
        next_grp1_valid = 1'b0;
        next_grp2_valid = 1'b0;
        next_stb1 = (stb1 != 2'h0) ? stb1 - 2'h1 : 2'h0;
        next_stb2 = (stb2 != 2'h0) ? stb2 - 2'h1 : 2'h0;
        // Change during a pending capture merges into it; the later level is latched
        if (pend[0]) begin
            next_dly1 = dly1 + 1'b1;
        end
        if (pend[1]) begin
            next_dly2 = dly2 + 1'b1;
        end
        if (capturing && chg1 && !pend[0]) begin
            next_pend[0] = 1'b1;
            next_dly1 = '0;
        end
        if (capturing && chg2 && !pend[1]) begin
            next_pend[1] = 1'b1;
            next_dly2 = '0;
        end
        if (cap1) begin
            next_pend[0] = 1'b0;
            next_grp1_valid = 1'b1;
            next_stb1 = STB_LAST + 2'h1;
            case (width_sel_i)
                lcc_pkg::LCC_WIDTH_8: next_grp1_data = {24'h000000, lines[7:0]};
                lcc_pkg::LCC_WIDTH_16: next_grp1_data = {16'h0000, lines[15:0]};
                default: next_grp1_data = lines;
            endcase
        end
        if (cap2) begin
            next_pend[1] = 1'b0;
            next_grp2_valid = 1'b1;
            next_stb2 = STB_LAST + 2'h1;
            if (width_sel_i == lcc_pkg::LCC_WIDTH_8) begin
                next_grp2_data = {8'h00, lines[23:16]};
            end else begin
                next_grp2_data = lines[31:16];
            end
        end
        if (!capturing) begin
            next_pend = 2'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= LCC_IDLE;
            ref_lines <= 32'h00000000;
            trig_start_d <= 1'b0;
            trig_stop_d <= 1'b0;
            samp_cnt <= PRE_W'(lcc_pkg::LCC_CNT_RST);
            post_cnt <= PRE_W'(lcc_pkg::LCC_CNT_RST);
            error_q <= 1'b0;
            done_q <= 1'b0;
            pend <= 2'h0;
            dly1 <= '0;
            dly2 <= '0;
            grp1_data <= 32'h00000000;
            grp2_data <= 16'h0000;
            grp1_valid <= 1'b0;
            grp2_valid <= 1'b0;
            stb1 <= 2'h0;
            stb2 <= 2'h0;
        end else begin
            state <= next_state;
            ref_lines <= next_ref_lines;
            trig_start_d <= next_trig_start_d;
            trig_stop_d <= next_trig_stop_d;
            samp_cnt <= next_samp_cnt;
            post_cnt <= next_post_cnt;
            error_q <= next_error_q;
            done_q <= next_done_q;
            pend <= next_pend;
            dly1 <= next_dly1;
            dly2 <= next_dly2;
            grp1_data <= next_grp1_data;
            grp2_data <= next_grp2_data;
            grp1_valid <= next_grp1_valid;
            grp2_valid <= next_grp2_valid;
            stb1 <= next_stb1;
            stb2 <= next_stb2;
        end
    end

    // Outputs registered; strobe is a register not a decode
    logic running_q;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            running_q <= 1'b0;
            grp1_strobe_o <= 1'b0;
            grp2_strobe_o <= 1'b0;
        end else begin
            running_q <= (next_state == LCC_RUN) || (next_state == LCC_POST);
            grp1_strobe_o <= (next_stb1 != 2'h0);
            grp2_strobe_o <= (next_stb2 != 2'h0);
        end
    end

    always_comb begin
        grp1_data_o = grp1_data;
        grp1_valid_o = grp1_valid;
        grp2_data_o = grp2_data;
        grp2_valid_o = grp2_valid;
        running_o = running_q;
        error_o = error_q;
        done_o = done_q;
    end
endmodule
`default_nettype wire

//--- lcc_capture_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_capture_chk #(
    parameter int PRE_W = 16
) (
    // Inputs watched
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [1:0] width_sel_i,
    input wire logic [1:0] trig_mode_i,
    input wire logic [31:0] line_mask_i,
    input wire logic config_load_i,
    input wire logic soft_start_i,
    input wire logic [7:0] port_zero_lines_i,
    // Outputs watched
    input wire logic [31:0] grp1_data_o,
    input wire logic grp1_valid_o,
    input wire logic grp1_strobe_o,
    input wire logic grp2_valid_o,
    input wire logic running_o,
    input wire logic error_o
);
    logic [7:0] prev_p0;
    always_ff @(posedge clk_i) begin
        prev_p0 <= port_zero_lines_i;
    end
    // Raw pin change; the bench spaces changes so pending captures never merge
    wire logic chg = running_o && width_sel_i != 2'h3
        && |((port_zero_lines_i ^ prev_p0) & line_mask_i[7:0]);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_STROBE: assert property ($rose(grp1_strobe_o) |=> grp1_strobe_o ##1 !grp1_strobe_o)
        else $error("strobe not two cycles");
    AST_VALID_STB: assert property (grp1_valid_o |-> $rose(grp1_strobe_o))
        else $error("valid without strobe start");
    AST_ONE_VALID: assert property (grp1_valid_o |=> !grp1_valid_o)
        else $error("valid longer than one cycle");
    AST_LATENCY: assert property (chg |-> ##[9:16] grp1_valid_o)
        else $error("change not captured in time");
    AST_W8_ZERO: assert property (grp1_valid_o && width_sel_i == lcc_pkg::LCC_WIDTH_8
        |-> grp1_data_o[31:8] == 24'h0) else $error("8-bit word not zero extended");
    AST_W32_G2: assert property (width_sel_i == lcc_pkg::LCC_WIDTH_32 |-> !grp2_valid_o)
        else $error("group 2 active in 32-bit mode");
    AST_HOLD: assert property ($changed(grp1_data_o) |-> grp1_valid_o)
        else $error("data changed without capture");
    AST_ERR_CLR: assert property (config_load_i || soft_start_i |=> !error_o)
        else $error("error not cleared");
    AST_SOFT_RUN: assert property (soft_start_i && !running_o && !config_load_i
        && trig_mode_i == lcc_pkg::LCC_TRIG_SOFT |=> running_o) else $error("no start");
    cover property (grp1_valid_o && width_sel_i == lcc_pkg::LCC_WIDTH_32);
    cover property ($rose(error_o));
    cover property ($rose(running_o));
endmodule
bind lcc_capture lcc_capture_chk #(.PRE_W(PRE_W)) u_chk (.clk_i, .srst_i, .width_sel_i,
    .trig_mode_i, .line_mask_i, .config_load_i, .soft_start_i, .port_zero_lines_i,
    .grp1_data_o, .grp1_valid_o, .grp1_strobe_o, .grp2_valid_o, .running_o, .error_o);
`default_nettype wire

//--- lcc_periph.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_periph (
    // Clock
    input wire logic clk_i,
    // Pins toward the capture block
    output logic [31:0] lines_o,
    output logic start_o,
    output logic stop_o
);
    initial begin
        lines_o = 32'h0;
        start_o = 1'b0;
        stop_o = 1'b0;
    end
    task automatic put(input logic [31:0] v);
        @(posedge clk_i);
        lines_o <= v;
    endtask
    // Held three cycles, longer than the two-stage synchroniser
    task automatic pulse(input logic stop);
        @(posedge clk_i);
        start_o <= !stop;
        stop_o <= stop;
        repeat (3) @(posedge clk_i);
        start_o <= 1'b0;
        stop_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- lcc_pkg.sv
package lcc_pkg;
    // Capture width codes
    localparam logic [1:0] LCC_WIDTH_8 = 2'h0;
    localparam logic [1:0] LCC_WIDTH_16 = 2'h1;
    localparam logic [1:0] LCC_WIDTH_32 = 2'h2;
    // Trigger modes
    localparam logic [1:0] LCC_TRIG_SOFT = 2'h0;
    localparam logic [1:0] LCC_TRIG_START = 2'h1;
    localparam logic [1:0] LCC_TRIG_STOP = 2'h2;
    localparam logic [1:0] LCC_TRIG_BOTH = 2'h3;
    // Timing: capture window after a change
    localparam int LCC_CLK_MHZ = 200;
    localparam int LCC_CAPT_MIN_NS = 50;
    localparam int LCC_CAPT_MAX_NS = 150;
    localparam int LCC_CAPT_MIN_CYC = (LCC_CAPT_MIN_NS * LCC_CLK_MHZ + 999) / 1000;
    localparam int LCC_CAPT_MAX_CYC = (LCC_CAPT_MAX_NS * LCC_CLK_MHZ) / 1000;
    // Strobe length in cycles
    localparam int LCC_STROBE_CYC = 2;
    localparam int LCC_CNT_W = 16;
    localparam logic [LCC_CNT_W-1:0] LCC_CNT_RST = 16'h0000;
endpackage

//--- lcc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module lcc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule
`default_nettype wire

//--- test_line_change_capture.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
end
module test_line_change_capture;
    logic clk_i;
    logic srst_i;
    logic [1:0] wsel;
    logic [1:0] tmode;
    logic [31:0] mask;
    logic [15:0] pre;
    logic [15:0] post;
    logic cload;
    logic sstart;
    logic [31:0] lines;
    logic strig, ptrig, g1v, g1s, g2v, g2s, run, err, done;
    logic [31:0] g1d;
    logic [15:0] g2d;
    int n_errors = 0;
    int n_checks = 0;
    int nv1 = 0;
    int nv2 = 0;
    int ns1 = 0;
    int ns2 = 0;
    int cyc = 0;
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    lcc_periph periph (.clk_i(clk_i), .lines_o(lines), .start_o(strig), .stop_o(ptrig));
    lcc_capture #(.PRE_W(16)) dut (
        .clk_i(clk_i), .srst_i(srst_i), .width_sel_i(wsel), .trig_mode_i(tmode),
        .line_mask_i(mask), .pretrig_cnt_i(pre), .posttrig_cnt_i(post),
        .config_load_i(cload), .soft_start_i(sstart),
        .port_zero_lines_i(lines[7:0]), .port_one_lines_i(lines[15:8]),
        .port_two_lines_i(lines[23:16]), .port_three_lines_i(lines[31:24]),
        .start_trigger_in_i(strig), .stop_trigger_in_i(ptrig),
        .grp1_data_o(g1d), .grp1_valid_o(g1v), .grp1_strobe_o(g1s),
        .grp2_data_o(g2d), .grp2_valid_o(g2v), .grp2_strobe_o(g2s),
        .running_o(run), .error_o(err), .done_o(done)
    );
    always @(posedge clk_i) begin
        cyc++;
        if (g1v === 1'b1) nv1++;
        if (g2v === 1'b1) nv2++;
        if (g1s === 1'b1) ns1++;
        if (g2s === 1'b1) ns2++;
        if (cyc == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic cfg(input logic [1:0] w, input logic [1:0] m, input logic [15:0] a,
                       input logic [15:0] b);
        @(posedge clk_i);
        wsel <= w;
        tmode <= m;
        mask <= 32'hffff_ffff;
        pre <= a;
        post <= b;
        cload <= 1'b1;
        @(posedge clk_i);
        cload <= 1'b0;
    endtask
    task automatic go();
        @(posedge clk_i);
        sstart <= 1'b1;
        @(posedge clk_i);
        sstart <= 1'b0;
    endtask
    task automatic t_width();
        logic [31:0] v;
        logic [31:0] keep [3] = '{32'hff, 32'hffff, 32'hffff_ffff};
        logic [1:0] wc [3] = '{lcc_pkg::LCC_WIDTH_8, lcc_pkg::LCC_WIDTH_16,
                               lcc_pkg::LCC_WIDTH_32};
        int c1;
        int c2;
        int s1;
        int s2;
        for (int i = 0; i < 3; i++) begin
            v = i[0] ? 32'ha5c3_691e : 32'h5a3c_96e1;
            cfg(wc[i], lcc_pkg::LCC_TRIG_SOFT, 16'h0, 16'h0);
            go();
            c1 = nv1;
            c2 = nv2;
            s1 = ns1;
            s2 = ns2;
            periph.put(v);
            wt(20);
            `CHK("nv1", c1 + 1, nv1)
            `CHK("g1d", v & keep[i], g1d)
            `CHK("nv2", c2 + (i < 2 ? 1 : 0), nv2)
            if (i < 2) `CHK("g2d", i ? v[31:16] : {8'h0, v[23:16]}, g2d)
            `CHK("ns1", s1 + lcc_pkg::LCC_STROBE_CYC, ns1)
            `CHK("ns2", s2 + (i < 2 ? lcc_pkg::LCC_STROBE_CYC : 0), ns2)
        end
        // Width code 3 is not a legal size and must capture nothing
        cfg(2'h3, lcc_pkg::LCC_TRIG_SOFT, 16'h0, 16'h0);
        go();
        c1 = nv1;
        c2 = nv2;
        periph.put(32'h0);
        wt(20);
        `CHK("w3", c1 + c2, nv1 + nv2)
    endtask
    task automatic t_mask();
        int c1;
        cfg(lcc_pkg::LCC_WIDTH_8, lcc_pkg::LCC_TRIG_SOFT, 16'h0, 16'h0);
        mask <= 32'h3;
        c1 = nv1;
        periph.put(32'h2);
        wt(20);
        `CHK("idle", c1, nv1)
        go();
        periph.put(32'h42);
        wt(20);
        `CHK("masked", c1, nv1)
        periph.put(32'h43);
        wt(20);
        `CHK("whole", 32'h43, g1d)
    endtask
    task automatic t_start();
        int c1;
        cfg(lcc_pkg::LCC_WIDTH_8, lcc_pkg::LCC_TRIG_START, 16'h0, 16'h0);
        go();
        c1 = nv1;
        periph.put(32'h0);
        wt(20);
        `CHK("armed", c1, nv1)
        periph.pulse(1'b0);
        wt(6);
        `CHK("run", 1'b1, run)
        periph.put(32'h7);
        wt(20);
        `CHK("nv1", c1 + 1, nv1)
    endtask
    task automatic t_stop();
        cfg(lcc_pkg::LCC_WIDTH_8, lcc_pkg::LCC_TRIG_STOP, 16'h2, 16'h1);
        go();
        // Spaced so each change is its own capture
        for (int i = 1; i < 4; i++) begin
            periph.put(32'(i) << 4);
            wt(20);
        end
        periph.pulse(1'b1);
        wt(6);
        `CHK("post", 1'b1, run)
        periph.put(32'h0);
        wt(20);
        `CHK("done", 1'b1, done)
        `CHK("stop", 1'b0, run | err)
    endtask
    task automatic t_err();
        cfg(lcc_pkg::LCC_WIDTH_8, lcc_pkg::LCC_TRIG_STOP, 16'h4, 16'h0);
        go();
        periph.put(32'h1);
        wt(20);
        periph.pulse(1'b1);
        wt(6);
        `CHK("err", 1'b1, err)
        go();
        wt(2);
        `CHK("clr", 2'b01, {err, run})
    endtask
    task automatic t_both();
        cfg(lcc_pkg::LCC_WIDTH_8, lcc_pkg::LCC_TRIG_BOTH, 16'h0, 16'h0);
        go();
        periph.pulse(1'b1);
        wt(6);
        `CHK("early", 1'b0, done | run)
        periph.pulse(1'b0);
        wt(6);
        `CHK("run", 1'b1, run)
        periph.pulse(1'b1);
        wt(6);
        `CHK("end", 1'b1, done)
    endtask
    initial begin
        srst_i <= 1'b1;
        wsel <= 2'h0;
        tmode <= 2'h0;
        mask <= 32'h0;
        pre <= 16'h0;
        post <= 16'h0;
        cload <= 1'b0;
        sstart <= 1'b0;
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        t_width();
        t_mask();
        t_start();
        t_stop();
        t_err();
        t_both();
        report_and_stop();
    end
endmodule
`default_nettype wire
